/* src/power_down_defines.vh */
`ifndef POWER_DOWN_DEFINES_VH
`define POWER_DOWN_DEFINES_VH

// ==========================================================
// Register map
`define ADDR_CTRL_PRIMARY 16'hFFF0
`define ADDR_CTRL_SECONDARY 16'hFFF1
`define ADDR_MODE_STATUS 16'hFFF2
`define RESET_CTRL_PRIMARY 8'h07
`define RESET_CTRL_SECONDARY 8'hE0
`define RESERVED_MASK_PRIMARY 8'h04
`define RESERVED_MASK_SECONDARY 8'hE0

// ==========================================================
// Primary control fields
`define BIT_DEEP_SLEEP 7
`define BIT_SETTLE_HI 6
`define BIT_SETTLE_LO 4
`define BIT_LOW_SPEED_ON 3
`define BIT_MEDIUM_DIVIDER_HI 1
`define BIT_MEDIUM_DIVIDER_LO 0

// ==========================================================
// Secondary control fields
`define BIT_NOISE_SAMPLE 4
`define BIT_DIRECT_TRANSFER 3
`define BIT_MEDIUM_SPEED_ON 2

// ==========================================================
// Timing counts in states
`define SETTLE_STATES_0 32'd8192
`define SETTLE_STATES_1 32'd16384
`define SETTLE_STATES_2 32'd32768
`define SETTLE_STATES_3 32'd65536
`define SETTLE_STATES_4 32'd131072
`define PRESCALER_WIDTH 13

`endif

/* src/settle_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "power_down_defines.vh"

module settle_timer
#(
    parameter SCALE_SHIFT = 0
)
(
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Control
    input wire i_start,
    input wire [2:0] i_settle_select,
    // Status
    output wire o_busy,
    output reg o_done
);

    // ==========================================================
    // Wait length from select code
    function [31:0] settle_states;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: settle_states = `SETTLE_STATES_0;
                3'h1: settle_states = `SETTLE_STATES_1;
                3'h2: settle_states = `SETTLE_STATES_2;
                3'h3: settle_states = `SETTLE_STATES_3;
                default: settle_states = `SETTLE_STATES_4;
            endcase
        end
    endfunction

    reg [31:0] count;
    wire [31:0] load_value;

    assign load_value = settle_states(i_settle_select) >> SCALE_SHIFT;
    assign o_busy = (count != 32'h00000000);

    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            count <= 32'h00000000;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            // Load one less: the registered done adds the last state
            if (i_start)
                count <= (load_value > 32'h00000001)
                    ? load_value - 32'h00000001 : 32'h00000001;
            else if (count != 32'h00000000)
            begin
                count <= count - 32'h00000001;
                if (count == 32'h00000001)
                    o_done <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* src/medium_divider.v */
`timescale 1ns/1ps
`default_nettype none
`include "power_down_defines.vh"

module medium_divider
(
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Control
    input wire i_run,
    input wire i_medium,
    input wire [1:0] i_divide_select,
    // Outputs
    output reg o_tick,
    output reg [`PRESCALER_WIDTH-1:0] o_prescaler
);

    reg [6:0] div_count;
    reg [6:0] div_last;

    // ==========================================================
    // Divide by 16, 32, 64 or 128
    always @*
    begin
        case (i_divide_select)
            2'h0: div_last = 7'h0F;
            2'h1: div_last = 7'h1F;
            2'h2: div_last = 7'h3F;
            default: div_last = 7'h7F;
        endcase
    end

    wire step;
    assign step = !i_medium || (div_count >= div_last);

    always @(posedge i_mclk)
    begin
        if (i_rst || !i_run)
        begin
            div_count <= 7'h00;
            o_tick <= 1'b0;
            o_prescaler <= {`PRESCALER_WIDTH{1'b0}};
        end
        else
        begin
            o_tick <= step;
            div_count <= step ? 7'h00 : div_count + 7'h01;
            if (step)
                o_prescaler <= o_prescaler
                    + {{(`PRESCALER_WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

/* src/power_down_mode_control.v */
// Behaviour
// - Wake-up from sleep modes begins only after interrupt accepted
// - Deepest halt tri-states ports, keeps data
// - Frozen modes ignore pin and edge requests except always-on; timebase still wakes, other interrupts wake standby only
// - Sub modes: timebase counts only when selected
// - Two control registers at FFF0, FFF1
// - Decode four wake interrupt groups
// - Sleep instruction picks mode by deep-sleep bit
// - Settle wait from three-bit select
// - Medium speed divides clock 16 to 128
// - Stopped system clock clears prescaler
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "power_down_defines.vh"

module power_down_mode_control
#(
    parameter SETTLE_SHIFT = 0
)
(
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Register port
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // CPU sequencing
    input wire i_sleep_exec,
    input wire i_irq_accepted,
    input wire i_timekeeping_sel,
    // Interrupt request pins
    input wire i_always_on_ext_request,
    input wire [3:1] i_ext_request,
    input wire [7:0] i_edge_request,
    input wire i_timebase_irq,
    input wire i_other_irq,
    // Mode state
    output reg [7:0] o_mode,
    output wire o_cpu_run,
    output wire o_sys_osc_run,
    output wire o_port_oe_n,
    output wire o_periph_reset,
    output wire o_ext_irq_freeze,
    output wire o_timebase_run,
    output wire o_sys_tick,
    output wire [`PRESCALER_WIDTH-1:0] o_system_clock_prescaler,
    output wire [3:0] o_wake_group,
    output wire [3:0] o_req_latched
);

    // ==========================================================
    // Mode states, one-hot
    localparam [7:0] M_ACTIVE_HI = 8'h01;
    localparam [7:0] M_ACTIVE_MED = 8'h02;
    localparam [7:0] M_SUBACTIVE = 8'h04;
    localparam [7:0] M_SLEEP = 8'h08;
    localparam [7:0] M_SUBSLEEP = 8'h10;
    localparam [7:0] M_WATCH = 8'h20;
    localparam [7:0] M_STANDBY = 8'h40;
    localparam [7:0] M_SETTLE = 8'h80;

    // ==========================================================
    // Pin synchronisers
    reg [11:0] sync_a;
    reg [11:0] sync_b;
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            sync_a <= 12'h000;
            sync_b <= 12'h000;
        end
        else
        begin
            sync_a <= {i_edge_request, i_ext_request,
                       i_always_on_ext_request};
            sync_b <= sync_a;
        end
    end

    wire always_on_ext_request_s;
    wire [3:1] irq_s;
    wire [7:0] edge_s;
    assign always_on_ext_request_s = sync_b[0];
    assign irq_s = sync_b[3:1];
    assign edge_s = sync_b[11:4];

    // ==========================================================
    // Control registers
    reg deep_sleep_select;
    reg [2:0] wakeup_settle_select;
    reg low_speed_on;
    reg medium_divider_hi;
    reg medium_divider_lo;
    reg noise_sample_fast;
    reg direct_transfer;
    reg medium_speed_on;

    wire [7:0] power_control_primary;
    wire [7:0] power_control_secondary;
    assign power_control_primary = {deep_sleep_select, wakeup_settle_select,
        low_speed_on, 1'b1, medium_divider_hi, medium_divider_lo};
    assign power_control_secondary = {3'h7, noise_sample_fast,
        direct_transfer, medium_speed_on, 2'h0};

    // Reset images, sliced per field
    wire [7:0] reset_primary;
    wire [7:0] reset_secondary;
    assign reset_primary = `RESET_CTRL_PRIMARY;
    assign reset_secondary = `RESET_CTRL_SECONDARY;

    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            {deep_sleep_select, wakeup_settle_select, low_speed_on}
                <= reset_primary[7:3];
            {medium_divider_hi, medium_divider_lo}
                <= reset_primary[1:0];
            {noise_sample_fast, direct_transfer, medium_speed_on}
                <= reset_secondary[4:2];
        end
        else if (i_wr && i_addr == `ADDR_CTRL_PRIMARY)
        begin
            deep_sleep_select <= i_wdata[`BIT_DEEP_SLEEP];
            wakeup_settle_select <= i_wdata[`BIT_SETTLE_HI:`BIT_SETTLE_LO];
            low_speed_on <= i_wdata[`BIT_LOW_SPEED_ON];
            medium_divider_hi <= i_wdata[`BIT_MEDIUM_DIVIDER_HI];
            medium_divider_lo <= i_wdata[`BIT_MEDIUM_DIVIDER_LO];
        end
        else if (i_wr && i_addr == `ADDR_CTRL_SECONDARY)
        begin
            noise_sample_fast <= i_wdata[`BIT_NOISE_SAMPLE];
            direct_transfer <= i_wdata[`BIT_DIRECT_TRANSFER];
            medium_speed_on <= i_wdata[`BIT_MEDIUM_SPEED_ON];
        end
    end

    // Read data one cycle after the strobe
    always @(posedge i_mclk)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                `ADDR_CTRL_PRIMARY: o_rdata <= power_control_primary;
                `ADDR_CTRL_SECONDARY: o_rdata <= power_control_secondary;
                `ADDR_MODE_STATUS: o_rdata <= o_mode;
                default: o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end

    // ==========================================================
    // Mode classification
    wire sys_stopped;
    wire frozen;
    wire sub_mode;
    assign sys_stopped = (o_mode == M_STANDBY) || (o_mode == M_WATCH) ||
        (o_mode == M_SUBACTIVE) || (o_mode == M_SUBSLEEP) ||
        (o_mode == M_SETTLE);
    assign frozen = (o_mode == M_STANDBY) || (o_mode == M_WATCH);
    assign sub_mode = (o_mode == M_WATCH) || (o_mode == M_SUBACTIVE) ||
        (o_mode == M_SUBSLEEP);

    // ==========================================================
    // Request flags, frozen inputs ignored
    reg [3:1] irq_flag;
    reg edge_any_flag;
    reg [3:1] irq_prev;
    reg [7:0] edge_prev;
    wire [3:1] irq_rise;
    wire edge_rise;
    assign irq_rise = irq_s & ~irq_prev;
    assign edge_rise = |(edge_s & ~edge_prev);

    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            irq_flag <= 3'h0;
            edge_any_flag <= 1'b0;
            irq_prev <= 3'h0;
            edge_prev <= 8'h00;
        end
        else
        begin
            irq_prev <= irq_s;
            edge_prev <= edge_s;
            if (!frozen)
            begin
                irq_flag <= irq_rise | (irq_flag & ~{3{i_irq_accepted}});
                edge_any_flag <= edge_rise |
                    (edge_any_flag & ~i_irq_accepted);
            end
        end
    end
    assign o_req_latched = {edge_any_flag, irq_flag};
    assign o_ext_irq_freeze = frozen;

    // ==========================================================
    // Wake groups
    wire ext_any;
    assign ext_any = always_on_ext_request_s | (|irq_flag);
    assign o_wake_group[0] = i_timebase_irq | always_on_ext_request_s;
    assign o_wake_group[1] = i_timebase_irq | ext_any | edge_any_flag;
    assign o_wake_group[2] = o_wake_group[1] | i_other_irq;
    assign o_wake_group[3] = irq_flag[1] | always_on_ext_request_s;

    // ==========================================================
    // Settle timer and clock divider
    wire settle_start;
    wire settle_done;
    settle_timer #(.SCALE_SHIFT(SETTLE_SHIFT)) u_settle
    (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_start(settle_start),
        .i_settle_select(wakeup_settle_select),
        .o_busy(),
        .o_done(settle_done)
    );

    medium_divider u_divider
    (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_run(!sys_stopped),
        .i_medium((o_mode == M_ACTIVE_MED) || (o_mode == M_SLEEP &&
            medium_speed_on)),
        .i_divide_select({medium_divider_hi, medium_divider_lo}),
        .o_tick(o_sys_tick),
        .o_prescaler(o_system_clock_prescaler)
    );

    // ==========================================================
    // Mode sequencer
    reg [7:0] next_mode;
    wire wake_to_sys;
    assign wake_to_sys = !low_speed_on;
    assign settle_start = i_irq_accepted && frozen && wake_to_sys &&
        ((o_mode == M_STANDBY) ? o_wake_group[2] : o_wake_group[0]);

    always @*
    begin
        next_mode = o_mode;
        case (o_mode)
            M_ACTIVE_HI, M_ACTIVE_MED:
                if (i_sleep_exec)
                    next_mode = deep_sleep_select ?
                        (i_timekeeping_sel ? M_WATCH : M_STANDBY)
                        : M_SLEEP;
            M_SUBACTIVE:
                if (i_sleep_exec)
                    next_mode = deep_sleep_select ? M_WATCH
                        : M_SUBSLEEP;
            M_SLEEP:
                if (i_irq_accepted)
                    next_mode = medium_speed_on ? M_ACTIVE_MED : M_ACTIVE_HI;
            M_SUBSLEEP:
                if (i_irq_accepted && o_wake_group[1])
                    next_mode = M_SUBACTIVE;
            M_WATCH, M_STANDBY:
                if (settle_start)
                    next_mode = M_SETTLE;
                else if (i_irq_accepted && !wake_to_sys &&
                    o_mode == M_WATCH && o_wake_group[0])
                    next_mode = M_SUBACTIVE;
            M_SETTLE:
                if (settle_done)
                    next_mode = medium_speed_on ? M_ACTIVE_MED : M_ACTIVE_HI;
            default:
                next_mode = M_ACTIVE_HI;
        endcase
    end

    always @(posedge i_mclk)
    begin
        if (i_rst)
            o_mode <= M_ACTIVE_HI;
        else
            o_mode <= next_mode;
    end

    // ==========================================================
    // Unit control per mode
    assign o_cpu_run = (o_mode == M_ACTIVE_HI) || (o_mode == M_ACTIVE_MED) ||
        (o_mode == M_SUBACTIVE);
    assign o_sys_osc_run = !sys_stopped || (o_mode == M_SETTLE);
    assign o_port_oe_n = (o_mode == M_STANDBY);
    assign o_periph_reset = sys_stopped && (o_mode != M_SETTLE);
    assign o_timebase_run = sub_mode ? i_timekeeping_sel
        : (o_mode != M_STANDBY);

endmodule

`default_nettype wire

/* bench/power_down_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_down_defines.vh"
module power_down_props
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Sequencing and requests
    input wire logic i_sleep_exec,
    input wire logic i_irq_accepted,
    input wire logic i_timekeeping_sel,
    input wire logic i_timebase_irq,
    input wire logic i_other_irq,
    // Mode outputs
    input wire logic [7:0] o_mode,
    input wire logic o_sys_osc_run,
    input wire logic o_port_oe_n,
    input wire logic o_ext_irq_freeze,
    input wire logic o_timebase_run,
    input wire logic [`PRESCALER_WIDTH-1:0] o_system_clock_prescaler,
    input wire logic [3:0] o_wake_group,
    input wire logic [3:0] o_req_latched
);
    // ==========================================================
    // Shadow of the deep-sleep select bit
    logic deep;
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            deep <= 1'h0;
        else if (i_wr && i_addr == 16'hFFF0)
            deep <= i_wdata[7];
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    // ==========================================================
    // Properties
    property p_mode_cause;
        $changed(o_mode) && $past(o_mode) != 8'h80
            |-> $past(i_sleep_exec) || $past(i_irq_accepted);
    endproperty
    a_mode_cause: assert property (p_mode_cause)
        else $error("mode changed without a cause");
    property p_sleep_light;
        o_mode == 8'h01 && i_sleep_exec && !deep |=> o_mode == 8'h08;
    endproperty
    a_sleep_light: assert property (p_sleep_light)
        else $error("light sleep entry wrong");
    property p_sleep_deep;
        o_mode == 8'h01 && i_sleep_exec && deep
            |=> o_mode == ($past(i_timekeeping_sel) ? 8'h20 : 8'h40);
    endproperty
    a_sleep_deep: assert property (p_sleep_deep)
        else $error("deep sleep entry wrong");
    property p_tristate;
        o_port_oe_n == (o_mode == 8'h40);
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("port drivers wrong for mode");
    property p_frozen;
        o_ext_irq_freeze && $past(o_ext_irq_freeze) && !$past(i_irq_accepted)
            |-> $stable(o_req_latched);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("request flags changed while frozen");
    property p_timebase;
        (o_mode & 8'h34) != 8'h00 |-> o_timebase_run == i_timekeeping_sel;
    endproperty
    a_timebase: assert property (p_timebase)
        else $error("timebase run wrong in sub modes");
    property p_reserved;
        i_rd && (i_addr == 16'hFFF0 || i_addr == 16'hFFF1)
            |=> $past(i_addr[0]) ? o_rdata[7:5] == 3'h7 : o_rdata[2];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not read as one");
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    property p_prescaler_clear;
        !o_sys_osc_run && !$past(o_sys_osc_run)
            |-> o_system_clock_prescaler == '0;
    endproperty
    a_prescaler_clear: assert property (p_prescaler_clear)
        else $error("prescaler not cleared while clock stopped");
    property p_group_any;
        $rose(i_other_irq) |-> ##[0:3] o_wake_group[2];
    endproperty
    a_group_any: assert property (p_group_any)
        else $error("any-interrupt group missing");
    property p_group_timebase;
        $rose(i_timebase_irq) |-> ##[0:3] o_wake_group[2:0] == 3'h7;
    endproperty
    a_group_timebase: assert property (p_group_timebase)
        else $error("timebase groups missing");
    property p_settle_bound;
        o_mode == 8'h80 |-> ##[1:600] o_mode != 8'h80;
    endproperty
    a_settle_bound: assert property (p_settle_bound)
        else $error("settling never ends");
endmodule

bind power_down_mode_control power_down_props u_props
(
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sleep_exec(i_sleep_exec), .i_irq_accepted(i_irq_accepted),
    .i_timekeeping_sel(i_timekeeping_sel), .i_timebase_irq(i_timebase_irq),
    .i_other_irq(i_other_irq), .o_mode(o_mode),
    .o_sys_osc_run(o_sys_osc_run), .o_port_oe_n(o_port_oe_n),
    .o_ext_irq_freeze(o_ext_irq_freeze), .o_timebase_run(o_timebase_run),
    .o_system_clock_prescaler(o_system_clock_prescaler),
    .o_wake_group(o_wake_group), .o_req_latched(o_req_latched)
);
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int SHIFT = 8;
    logic i_mclk = 1'h0;
    logic i_rst = 1'h1;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'h0;
    logic i_rd = 1'h0;
    logic i_sleep_exec = 1'h0;
    logic i_irq_accepted = 1'h0;
    logic i_timekeeping_sel = 1'h0;
    logic i_always_on_ext_request = 1'h0;
    logic [3:1] i_ext_request = 3'h0;
    logic [7:0] i_edge_request = 8'h00;
    logic i_timebase_irq = 1'h0;
    logic i_other_irq = 1'h0;
    logic [7:0] o_rdata, o_mode;
    logic o_cpu_run, o_sys_osc_run, o_port_oe_n, o_periph_reset;
    logic o_ext_irq_freeze, o_timebase_run, o_sys_tick;
    logic [12:0] o_system_clock_prescaler;
    logic [3:0] o_wake_group, o_req_latched;
    int error_cnt = 0;
    int compares = 0;

    always #2.5 i_mclk = ~i_mclk;

    power_down_mode_control #(.SETTLE_SHIFT(SHIFT)) DUT
    (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sleep_exec(i_sleep_exec), .i_irq_accepted(i_irq_accepted),
        .i_timekeeping_sel(i_timekeeping_sel),
        .i_always_on_ext_request(i_always_on_ext_request),
        .i_ext_request(i_ext_request), .i_edge_request(i_edge_request),
        .i_timebase_irq(i_timebase_irq), .i_other_irq(i_other_irq),
        .o_mode(o_mode), .o_cpu_run(o_cpu_run), .o_sys_osc_run(o_sys_osc_run),
        .o_port_oe_n(o_port_oe_n), .o_periph_reset(o_periph_reset),
        .o_ext_irq_freeze(o_ext_irq_freeze), .o_timebase_run(o_timebase_run),
        .o_sys_tick(o_sys_tick),
        .o_system_clock_prescaler(o_system_clock_prescaler),
        .o_wake_group(o_wake_group), .o_req_latched(o_req_latched)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic half();
        @(negedge i_mclk);
    endtask
    task automatic do_reset();
        i_rst <= 1'h1;
        step(4);
        i_rst <= 1'h0;
        step(1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        step(1);
        i_wr <= 1'h0;
        step(1);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        i_rd <= 1'h1;
        i_addr <= a;
        step(1);
        i_rd <= 1'h0;
        half();
        d = o_rdata;
        step(1);
    endtask
    task automatic pulse_sleep();
        i_sleep_exec <= 1'h1;
        step(1);
        i_sleep_exec <= 1'h0;
    endtask
    task automatic pulse_accept();
        i_irq_accepted <= 1'h1;
        step(1);
        i_irq_accepted <= 1'h0;
    endtask
    task automatic settle_count(output int c);
        c = 0;
        half();
        while (o_mode === 8'h80 && c < 2000)
        begin
            @(negedge i_mclk);
            c++;
        end
    endtask
    task automatic tick_gap(output int c);
        c = 0;
        @(negedge i_mclk);
        while (o_sys_tick !== 1'h1 && c < 300)
        begin
            @(negedge i_mclk);
            c++;
        end
    endtask
    task automatic standby_wake(input logic [7:0] p, input logic [7:0] s,
                                input logic [7:0] m, input int n);
        int cnt;
        wr(16'hFFF0, p);
        wr(16'hFFF1, s);
        pulse_sleep();
        half();
        chk(o_mode, 8'h40);
        chk(o_port_oe_n, 1'h1);
        chk(o_ext_irq_freeze, 1'h1);
        step(1);
        i_ext_request <= 3'h7;
        step(4);
        half();
        chk(o_req_latched, 4'h0);
        chk(o_system_clock_prescaler, 13'h0000);
        step(1);
        i_ext_request <= 3'h0;
        step(3);
        i_other_irq <= 1'h1;
        step(1);
        pulse_accept();
        i_other_irq <= 1'h0;
        settle_count(cnt);
        chk(cnt, n);
        chk(o_mode, m);
        chk(o_port_oe_n, 1'h0);
        step(1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [7:0] d;
        rd(16'hFFF0, d);
        chk(d, 8'h07);
        rd(16'hFFF1, d);
        chk(d, 8'hE0);
        wr(16'hFFF0, 8'h00);
        rd(16'hFFF0, d);
        chk(d, 8'h04);
        wr(16'hFFF1, 8'h1F);
        rd(16'hFFF1, d);
        chk(d, 8'hFC);
        wr(16'h0123, 8'hAA);
        rd(16'h0123, d);
        chk(d, 8'h00);
        half();
        chk(o_system_clock_prescaler != 13'h0000, 1'h1);
        step(1);
        do_reset();
        $display("test regs done");
    endtask
    task automatic t_groups();
        logic [3:0] exp [6] = '{4'hF, 4'hE, 4'h6, 4'h6, 4'h7, 4'h4};
        for (int k = 0; k < 6; k++)
        begin
            {i_other_irq, i_timebase_irq, i_edge_request[5], i_ext_request[3],
             i_ext_request[1], i_always_on_ext_request} <= 6'h01 << k;
            step(5);
            half();
            chk(o_wake_group, exp[k]);
            step(1);
            {i_other_irq, i_timebase_irq, i_edge_request[5], i_ext_request[3],
             i_ext_request[1], i_always_on_ext_request} <= 6'h00;
            do_reset();
        end
        $display("test groups done");
    endtask
    task automatic t_sleep();
        wr(16'hFFF0, 8'h07);
        pulse_sleep();
        half();
        chk(o_mode, 8'h08);
        chk(o_cpu_run, 1'h0);
        step(1);
        i_other_irq <= 1'h1;
        step(6);
        half();
        chk(o_mode, 8'h08);
        step(1);
        pulse_accept();
        i_other_irq <= 1'h0;
        half();
        chk(o_mode, 8'h01);
        step(1);
        $display("test sleep done");
    endtask
    task automatic t_settle();
        for (int s = 0; s < 6; s++)
            standby_wake({1'h1, (s == 5) ? 3'h7 : s[2:0], 4'h7}, 8'hE0, 8'h01,
                         (8192 << ((s > 4) ? 4 : s)) >> SHIFT);
        $display("test settle done");
    endtask
    task automatic t_medium();
        int c;
        for (int ma = 0; ma < 4; ma++)
        begin
            do_reset();
            standby_wake({6'h20, ma[1:0]}, 8'h04, 8'h02, 8192 >> SHIFT);
            tick_gap(c);
            tick_gap(c);
            chk(c + 1, 16 << ma);
            step(1);
        end
        $display("test medium done");
    endtask
    task automatic t_watch();
        int c;
        do_reset();
        wr(16'hFFF0, 8'h87);
        i_timekeeping_sel <= 1'h1;
        pulse_sleep();
        half();
        chk(o_mode, 8'h20);
        chk(o_timebase_run, 1'h1);
        step(1);
        i_timekeeping_sel <= 1'h0;
        half();
        chk(o_timebase_run, 1'h0);
        step(1);
        i_timebase_irq <= 1'h1;
        step(1);
        pulse_accept();
        i_timebase_irq <= 1'h0;
        settle_count(c);
        chk(c, 8192 >> SHIFT);
        chk(o_mode, 8'h01);
        step(1);
        $display("test watch done");
    endtask

    task automatic t_sub();
        logic [7:0] d;
        do_reset();
        wr(16'hFFF0, 8'h8F);
        i_timekeeping_sel <= 1'h1;
        pulse_sleep();
        step(1);
        i_timebase_irq <= 1'h1;
        pulse_accept();
        i_timebase_irq <= 1'h0;
        half();
        chk(o_mode, 8'h04);
        chk(o_cpu_run, 1'h1);
        chk(o_sys_osc_run, 1'h0);
        chk(o_periph_reset, 1'h1);
        chk(o_timebase_run, 1'h1);
        step(1);
        wr(16'hFFF0, 8'h0F);
        pulse_sleep();
        half();
        chk(o_mode, 8'h10);
        step(1);
        i_ext_request <= 3'h4;
        step(4);
        half();
        chk(o_req_latched, 4'h4);
        step(1);
        pulse_accept();
        i_ext_request <= 3'h0;
        half();
        chk(o_mode, 8'h04);
        step(1);
        rd(16'hFFF2, d);
        chk(d, 8'h04);
        i_timekeeping_sel <= 1'h0;
        $display("test sub done");
    endtask

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        step(20);
        i_rst <= 1'h0;
        step(1);
        t_regs();
        t_groups();
        t_sleep();
        t_settle();
        t_medium();
        t_sub();
        t_watch();
        report_and_stop();
    end
    initial
    begin
        step(20000);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
